// File: logic/asbmp_map.svh
// Purpose: constants for the system-bus master port and its far end
// Assumes: included by bare name from the modules and the testbench, not the package
// Notes:   codes are two-bit bus encodings
`ifndef ASBMP_MAP_SVH
`define ASBMP_MAP_SVH

// --------------------------------------------------------------------
// transfer type codes
// --------------------------------------------------------------------
`define ASBMP_TRAN_ADDR    2'h0
`define ASBMP_TRAN_NSEQ    2'h1
`define ASBMP_TRAN_SEQ     2'h3

// --------------------------------------------------------------------
// transfer size codes
// --------------------------------------------------------------------
`define ASBMP_SIZE_BYTE    2'h0
`define ASBMP_SIZE_HALF    2'h1
`define ASBMP_SIZE_WORD    2'h2

// --------------------------------------------------------------------
// burst length codes
// --------------------------------------------------------------------
`define ASBMP_BURST_NONE   2'h0
`define ASBMP_BURST_4      2'h1
`define ASBMP_BURST_8      2'h2
`define ASBMP_BURST_UNDEF  2'h3

// --------------------------------------------------------------------
// reset, test-slave and word-step constants
// --------------------------------------------------------------------
`define ASBMP_RESET_CYCLES 5
`define ASBMP_TSLV_LSB     2
`define ASBMP_TSLV_MSB     11
`define ASBMP_TSLV_REGS    1024
`define ASBMP_WORD_STEP    32'h0000_0004

`endif

// File: logic/asbmp_pkg.sv
// Purpose: shared types of the bus master port
// Assumes: asbmp_map.svh holds the numbers
// Notes:   states of the master sequencer live here
package asbmp_pkg;
    // master sequencer states
    typedef enum logic [2:0] {
        M_IDLE,
        M_REQ,
        M_ADDR,
        M_DATA,
        M_DONE
    } asbmp_mst_e;

    // one queued transfer as seen by the master
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic        lock;
        logic [1:0]  prot;
        logic [1:0]  size;
        logic [1:0]  burst;
    } asbmp_cmd_s;
endpackage

// File: logic/asbmp_if.sv
// Purpose: shared system bus between the master port and its far end
// Assumes: single clock, shared lines resolved by the testbench
// Notes:   address, data and transfer-type lines travel with their enables
`timescale 1ns/1ps
interface asbmp_if;
    // master to bus
    logic        bus_request_out;
    logic        addr_strobe_out;
    logic [31:0] addr_out_bus;
    logic        write_out;
    logic        lock_out;
    logic [1:0]  prot_out;
    logic [1:0]  size_out;
    logic [1:0]  burst_out;
    logic [1:0]  ttype_out;
    logic [31:0] wdata_out;
    logic        addr_drive_enable;
    logic        data_drive_enable;
    logic        ttype_drive_enable;
    // bus to master
    logic        bus_grant_in;
    logic        wait_resp_in;
    logic [31:0] rdata_in;
    logic [11:2] test_slave_addr_in;
    logic        test_slave_select;
    logic        test_write_in;
    logic [31:0] test_wdata_in;
    // master as test slave back to bus
    logic        test_wait_out;
    logic [31:0] test_rdata_out;

    modport dev
    (
        output bus_request_out, addr_strobe_out, addr_out_bus, write_out,
        output lock_out, prot_out, size_out, burst_out, ttype_out,
        output wdata_out, addr_drive_enable, data_drive_enable,
        output ttype_drive_enable, test_wait_out, test_rdata_out,
        input  bus_grant_in, wait_resp_in, rdata_in, test_slave_addr_in,
        input  test_slave_select, test_write_in, test_wdata_in
    );

    modport far
    (
        input  bus_request_out, addr_strobe_out, addr_out_bus, write_out,
        input  lock_out, prot_out, size_out, burst_out, ttype_out,
        input  wdata_out, addr_drive_enable, data_drive_enable,
        input  ttype_drive_enable, test_wait_out, test_rdata_out,
        output bus_grant_in, wait_resp_in, rdata_in, test_slave_addr_in,
        output test_slave_select, test_write_in, test_wdata_in
    );
endinterface

// File: logic/asbmp_master.sv
// Purpose: system-bus master port with request, strobe and test slave
// Assumes: the far end keeps grant, wait and reset rules
// Notes:   single rising-edge clock stands for both bus clock phases
`timescale 1ns/1ps
`include "asbmp_map.svh"

module asbmp_master
(
    input  wire logic                CLK,
    input  wire logic                RESET_N,
    asbmp_if.dev                     BUS,
    input  wire logic                CMD_VALID,
    output logic                     CMD_READY,
    input  wire asbmp_pkg::asbmp_cmd_s CMD,
    output logic                     RSP_VALID,
    output logic [31:0]              RSP_RDATA
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    asbmp_pkg::asbmp_mst_e state;
    asbmp_pkg::asbmp_mst_e next_state;
    asbmp_pkg::asbmp_cmd_s cur;
    asbmp_pkg::asbmp_cmd_s next_cur;
    logic [3:0]            beats;
    logic [3:0]            next_beats;
    logic                  rsp_valid;
    logic                  next_rsp_valid;
    logic [31:0]           rsp_rdata;
    logic [31:0]           next_rsp_rdata;
    logic                  owned;

    // ------------------------------------------------------------------
    // test slave store
    // ------------------------------------------------------------------
    logic [31:0] tslv_mem [0:`ASBMP_TSLV_REGS-1];
    logic [31:0] tslv_rdata;
    logic [31:0] next_tslv_rdata;
    logic        tslv_wait;
    logic        next_tslv_wait;

    // ownership: grant alone is not enough while a slave stretches
    assign owned = BUS.bus_grant_in && !BUS.wait_resp_in;

    // burst length to beat count
    function automatic logic [3:0] burst_beats(input logic [1:0] code);
        case (code)
            `ASBMP_BURST_4: burst_beats = 4'h4;
            `ASBMP_BURST_8: burst_beats = 4'h8;
            default:        burst_beats = 4'h1;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // master sequencer
    // ------------------------------------------------------------------
    // wait high freezes cur, so address and data stay put
    always_comb
    begin
        next_state     = state;
        next_cur       = cur;
        next_beats     = beats;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        case (state)
            asbmp_pkg::M_IDLE:
            begin
                if (CMD_VALID)
                begin
                    next_cur = CMD;
                    if (CMD.size == 2'h3)
                        next_cur.size = `ASBMP_SIZE_WORD;
                    next_beats = burst_beats(CMD.burst);
                    next_state = asbmp_pkg::M_REQ;
                end
            end
            asbmp_pkg::M_REQ:
            begin
                if (owned)
                    next_state = asbmp_pkg::M_ADDR;
            end
            asbmp_pkg::M_ADDR:
            begin
                next_state = asbmp_pkg::M_DATA;
            end
            asbmp_pkg::M_DATA:
            begin
                if (!BUS.wait_resp_in)
                begin
                    next_rsp_valid = 1'b1;
                    next_rsp_rdata = BUS.rdata_in;
                    if (beats > 4'h1 && BUS.bus_grant_in)
                    begin
                        next_beats    = beats - 4'h1;
                        next_cur.addr = cur.addr + `ASBMP_WORD_STEP;
                        next_state    = asbmp_pkg::M_ADDR;
                    end
                    else
                        next_state = asbmp_pkg::M_DONE;
                end
            end
            asbmp_pkg::M_DONE:
            begin
                next_state = asbmp_pkg::M_IDLE;
            end
            default:
            begin
                next_state = asbmp_pkg::M_IDLE;
            end
        endcase
    end

    // registers of the sequencer; reset timing is the far end's duty
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state     <= asbmp_pkg::M_IDLE;
            cur       <= '0;
            beats     <= 4'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 32'h0000_0000;
        end
        else
        begin
            state     <= next_state;
            cur       <= next_cur;
            beats     <= next_beats;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
        end
    end

    // ------------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------------
    // first beat is nonsequential, later beats of a burst sequential
    logic first_beat;
    assign first_beat = (beats == burst_beats(cur.burst));

    assign BUS.bus_request_out = (state == asbmp_pkg::M_REQ)
                              || (state == asbmp_pkg::M_ADDR)
                              || (state == asbmp_pkg::M_DATA);
    assign BUS.addr_strobe_out = (state == asbmp_pkg::M_ADDR);
    assign BUS.addr_out_bus    = cur.addr;
    assign BUS.write_out       = cur.write;
    assign BUS.lock_out        = cur.lock;
    assign BUS.prot_out        = cur.prot;
    assign BUS.size_out        = cur.size;
    assign BUS.burst_out       = cur.burst;
    assign BUS.wdata_out       = cur.wdata;
    assign BUS.ttype_out       = (state == asbmp_pkg::M_ADDR)
                              ? (first_beat ? `ASBMP_TRAN_NSEQ
                                            : `ASBMP_TRAN_SEQ)
                              : `ASBMP_TRAN_ADDR;
    assign BUS.addr_drive_enable  = BUS.bus_grant_in
                                 && ((state == asbmp_pkg::M_ADDR)
                                 || (state == asbmp_pkg::M_DATA));
    assign BUS.data_drive_enable  = BUS.bus_grant_in && cur.write
                                 && (state == asbmp_pkg::M_DATA);
    assign BUS.ttype_drive_enable = BUS.bus_grant_in
                                 && (state != asbmp_pkg::M_IDLE);

    assign CMD_READY = (state == asbmp_pkg::M_IDLE);
    assign RSP_VALID = rsp_valid;
    assign RSP_RDATA = rsp_rdata;

    // ------------------------------------------------------------------
    // test slave
    // ------------------------------------------------------------------
    // one wait cycle per access keeps the read path registered
    always_comb
    begin
        next_tslv_wait  = 1'b0;
        next_tslv_rdata = tslv_rdata;
        if (BUS.test_slave_select && !tslv_wait)
        begin
            next_tslv_wait  = 1'b1;
            next_tslv_rdata = tslv_mem[BUS.test_slave_addr_in];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tslv_wait  <= 1'b0;
            tslv_rdata <= 32'h0000_0000;
        end
        else
        begin
            tslv_wait  <= next_tslv_wait;
            tslv_rdata <= next_tslv_rdata;
        end
    end

    // vector store has no reset, it is plain memory
    always_ff @(posedge CLK)
    begin
        if (BUS.test_slave_select && BUS.test_write_in && !tslv_wait)
            tslv_mem[BUS.test_slave_addr_in] <= BUS.test_wdata_in;
    end

    assign BUS.test_wait_out  = BUS.test_slave_select && !tslv_wait;
    assign BUS.test_rdata_out = tslv_rdata;

endmodule

// File: logic/asbmp_far.sv
// Purpose: far end: arbiter, test-vector driver and a slave with WAITS wait states
// Assumes: a single master on the bus
// Notes:   also makes the core reset with its minimum width
`timescale 1ns/1ps
`include "asbmp_map.svh"

module asbmp_far
#(
    parameter int WAITS = 1
)
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    asbmp_if.far             BUS,
    input  wire logic        RESET_REQ,
    output logic             CORE_RESET_N,
    input  wire logic        TEST_VALID,
    input  wire logic        TEST_WRITE,
    input  wire logic [11:2] TEST_ADDR,
    input  wire logic [31:0] TEST_WDATA,
    output logic             TEST_DONE,
    output logic [31:0]      TEST_RDATA
);

    // ------------------------------------------------------------------
    // reset stretcher
    // ------------------------------------------------------------------
    logic [2:0] rst_cnt;
    logic [2:0] next_rst_cnt;
    logic       core_rst_n;
    logic       next_core_rst_n;
    logic       core_rst_lo;
    logic       grant;
    logic       next_grant;
    logic [7:0] wcnt;
    logic [7:0] next_wcnt;
    logic [31:0] mem;
    logic [31:0] next_mem;
    logic       tdone;
    logic       next_tdone;
    logic [31:0] trdata;
    logic [31:0] next_trdata;

    // width counted on the rising edge; release retimed to the low phase
    always_comb
    begin
        next_rst_cnt    = rst_cnt;
        next_core_rst_n = core_rst_n;
        if (RESET_REQ)
        begin
            next_rst_cnt    = 3'(`ASBMP_RESET_CYCLES);
            next_core_rst_n = 1'b0;
        end
        else if (rst_cnt != 3'h0)
            next_rst_cnt = rst_cnt - 3'h1;
        else
            next_core_rst_n = 1'b1;
    end

    // ------------------------------------------------------------------
    // arbiter and slave
    // ------------------------------------------------------------------
    // single master: grant follows request, held during wait
    always_comb
    begin
        next_grant = BUS.bus_request_out;
        next_wcnt  = wcnt;
        next_mem   = mem;
        if (BUS.addr_strobe_out)
            next_wcnt = 8'(WAITS);
        else if (wcnt != 8'h00)
            next_wcnt = wcnt - 8'h01;
        if (BUS.data_drive_enable && wcnt == 8'h00)
            next_mem = BUS.wdata_out;
    end

    // drive test vectors into the master acting as slave
    always_comb
    begin
        next_tdone  = 1'b0;
        next_trdata = trdata;
        if (TEST_VALID && !BUS.test_wait_out && !tdone)
        begin
            next_tdone  = 1'b1;
            next_trdata = BUS.test_rdata_out;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_cnt    <= 3'(`ASBMP_RESET_CYCLES);
            core_rst_n <= 1'b0;
            grant      <= 1'b0;
            wcnt       <= 8'h00;
            mem        <= 32'h0000_0000;
            tdone      <= 1'b0;
            trdata     <= 32'h0000_0000;
        end
        else
        begin
            rst_cnt    <= next_rst_cnt;
            core_rst_n <= next_core_rst_n;
            grant      <= next_grant;
            wcnt       <= next_wcnt;
            mem        <= next_mem;
            tdone      <= next_tdone;
            trdata     <= next_trdata;
        end
    end

    // falling-edge copy: core reset only ever lifts while the clock is low
    always_ff @(negedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            core_rst_lo <= 1'b0;
        else
            core_rst_lo <= core_rst_n;
    end

    assign CORE_RESET_N           = core_rst_lo;
    assign BUS.bus_grant_in       = grant;
    assign BUS.wait_resp_in       = (wcnt != 8'h00);
    assign BUS.rdata_in           = mem;
    assign BUS.test_slave_select  = TEST_VALID && !tdone;
    assign BUS.test_slave_addr_in = TEST_ADDR;
    assign BUS.test_write_in      = TEST_WRITE;
    assign BUS.test_wdata_in      = TEST_WDATA;
    assign TEST_DONE              = tdone;
    assign TEST_RDATA             = trdata;

endmodule

// File: dv/asbmp_assertions.sv
// Purpose: wire checks on the shared bus between master and far end
// Assumes: RESET_N is the core reset seen by the master
// Notes:   instantiated beside the interface, no bind
`timescale 1ns/1ps
`include "asbmp_map.svh"

module asbmp_assertions
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        bus_request_out,
    input wire logic        addr_strobe_out,
    input wire logic [31:0] addr_out_bus,
    input wire logic        write_out,
    input wire logic [1:0]  size_out,
    input wire logic [1:0]  ttype_out,
    input wire logic [31:0] wdata_out,
    input wire logic        addr_drive_enable,
    input wire logic        data_drive_enable,
    input wire logic        ttype_drive_enable,
    input wire logic        bus_grant_in,
    input wire logic        wait_resp_in,
    input wire logic        test_wait_out,
    input wire logic        test_slave_select
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    logic [31:0] last_addr;
    logic [31:0] next_last_addr;

    // ------------------------------------------------------------
    // helper: address of the last strobed beat
    // ------------------------------------------------------------
    always_comb
    begin
        next_last_addr = addr_strobe_out ? addr_out_bus : last_addr;
    end

    // kept apart so a burst step is judged against the beat before
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            last_addr <= 32'h0000_0000;
        else
            last_addr <= next_last_addr;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    own_needs_grant_a:
        assert property (addr_drive_enable |-> bus_grant_in)
            else $error("address lines driven without grant");
    req_before_own_a:
        assert property ($rose(addr_drive_enable) |-> $past(bus_request_out))
            else $error("bus taken without a request");
    strobe_owner_a:
        assert property (addr_strobe_out |-> bus_grant_in && addr_drive_enable)
            else $error("strobe outside bus ownership");
    data_en_write_a:
        assert property (data_drive_enable |-> write_out && addr_drive_enable)
            else $error("data lines driven outside a write");
    size_legal_a:
        assert property (addr_drive_enable |-> size_out != 2'h3)
            else $error("reserved size driven");
    ttype_legal_a:
        assert property (ttype_drive_enable |-> ttype_out != 2'h2)
            else $error("undefined transfer type driven");
    hold_on_wait_a:
        assert property (wait_resp_in && addr_drive_enable |=>
            $stable(addr_out_bus) && $stable(write_out) && $stable(wdata_out))
            else $error("outputs moved while wait high");
    seq_addr_step_a:
        assert property (addr_strobe_out && ttype_out == `ASBMP_TRAN_SEQ
            |-> addr_out_bus == last_addr + `ASBMP_WORD_STEP)
            else $error("sequential beat not one word on");
    test_wait_short_a:
        assert property (test_wait_out |=> !test_wait_out)
            else $error("test wait longer than one cycle");

    cover property (addr_strobe_out && write_out);
    cover property (addr_strobe_out && ttype_out == `ASBMP_TRAN_SEQ);
    cover property (wait_resp_in && addr_drive_enable);
    cover property (test_slave_select);
endmodule

// File: dv/tb_asb_bus_master_port.sv
// Purpose: master and far end joined, driven from both user sides
// Assumes: far end grants a single master one cycle after request
// Notes:   outputs sampled on the falling edge where settled
`timescale 1ns/1ps
`include "asbmp_map.svh"

module tb_asb_bus_master_port;
    logic                CLK;
    logic                rst_n;
    logic                core_rst_n;
    logic                reset_req;
    logic                cmd_valid;
    logic                cmd_ready;
    asbmp_pkg::asbmp_cmd_s cmd;
    logic                rsp_valid;
    logic [31:0]         rsp_rdata;
    logic                test_valid;
    logic                test_write;
    logic [11:2]         test_addr;
    logic [31:0]         test_wdata;
    logic                test_done;
    logic [31:0]         test_rdata;
    int                  n_fail;
    int                  n_compared;
    logic [31:0]         wr_last;

    asbmp_if bus();

    // two wait cycles per beat so every beat stalls
    asbmp_far #(.WAITS(2)) asbmp_far_i
    (
        .CLK(CLK), .RESET_N(rst_n), .BUS(bus), .RESET_REQ(reset_req),
        .CORE_RESET_N(core_rst_n), .TEST_VALID(test_valid),
        .TEST_WRITE(test_write), .TEST_ADDR(test_addr),
        .TEST_WDATA(test_wdata), .TEST_DONE(test_done),
        .TEST_RDATA(test_rdata)
    );

    asbmp_master asbmp_master_i
    (
        .CLK(CLK), .RESET_N(core_rst_n), .BUS(bus),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata)
    );

    asbmp_assertions asbmp_assertions_i
    (
        .CLK(CLK), .RESET_N(core_rst_n),
        .bus_request_out(bus.bus_request_out),
        .addr_strobe_out(bus.addr_strobe_out),
        .addr_out_bus(bus.addr_out_bus), .write_out(bus.write_out),
        .size_out(bus.size_out), .ttype_out(bus.ttype_out),
        .wdata_out(bus.wdata_out),
        .addr_drive_enable(bus.addr_drive_enable),
        .data_drive_enable(bus.data_drive_enable),
        .ttype_drive_enable(bus.ttype_drive_enable),
        .bus_grant_in(bus.bus_grant_in), .wait_resp_in(bus.wait_resp_in),
        .test_wait_out(bus.test_wait_out),
        .test_slave_select(bus.test_slave_select)
    );

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    always #20 CLK = ~CLK;

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout_hit;
        n_fail++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop;
    endtask

    // one command, watching every strobed beat on the wire
    task automatic run_cmd(input asbmp_pkg::asbmp_cmd_s c, input int beats);
        int         k;
        int         ns;
        int         nr;
        logic       req_seen;
        logic [1:0] sz;
        ns = 0;
        nr = 0;
        req_seen = 1'b0;
        sz = (c.size == 2'h3) ? `ASBMP_SIZE_WORD : c.size;
        @(posedge CLK);
        cmd_valid <= 1'b1;
        cmd <= c;
        k = 0;
        do
        begin
            @(negedge CLK);
            k++;
        end
        while (cmd_ready !== 1'b1 && k < 50);
        if (cmd_ready !== 1'b1)
            timeout_hit;
        @(posedge CLK);
        cmd_valid <= 1'b0;
        for (k = 0; k < 150; k++)
        begin
            @(negedge CLK);
            if (bus.bus_request_out === 1'b1)
                req_seen = 1'b1;
            if (bus.addr_strobe_out === 1'b1)
            begin
                check(bus.addr_out_bus, c.addr + 32'(ns) * 32'h4);
                check(32'(bus.ttype_out), (ns == 0) ? 32'h1 : 32'h3);
                check(32'({bus.write_out, bus.size_out, bus.burst_out}),
                    32'({c.write, sz, c.burst}));
                check(32'({bus.lock_out, bus.prot_out}),
                    32'({c.lock, c.prot}));
                ns++;
            end
            if (bus.data_drive_enable === 1'b1)
                check(bus.wdata_out, c.wdata);
            if (rsp_valid === 1'b1)
            begin
                nr++;
                if (!c.write)
                    check(rsp_rdata, wr_last);
            end
            if (nr == beats && cmd_ready === 1'b1)
                break;
        end
        if (k == 150)
            timeout_hit;
        // far end keeps the last written word for later reads
        if (c.write)
            wr_last = c.wdata;
        check(32'(ns), 32'(beats));
        check(32'(nr), 32'(beats));
        check(32'(req_seen), 32'h1);
        check(32'(bus.bus_request_out), 32'h0);
    endtask

    task automatic test_acc(input logic w, input logic [11:2] a,
        input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge CLK);
        test_valid <= 1'b1;
        test_write <= w;
        test_addr <= a;
        test_wdata <= d;
        k = 0;
        do
        begin
            @(negedge CLK);
            k++;
        end
        while (test_done !== 1'b1 && k < 20);
        if (k == 20)
            timeout_hit;
        q = test_rdata;
        @(posedge CLK);
        test_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every size code, reserved one last, reads and writes mixed
    task automatic t_sizes;
        asbmp_pkg::asbmp_cmd_s c;
        c = '0;
        for (int s = 0; s < 4; s++)
        begin
            c.addr = 32'h0000_1000 + 32'(s) * 32'h10;
            c.wdata = 32'hC0DE_0000 + 32'(s);
            c.size = 2'(s);
            c.write = ~c.size[0];
            c.prot = 2'(s);
            run_cmd(c, 1);
        end
        $display("test sizes done");
    endtask

    // every burst code; lengths 4 and 8 stream sequential beats
    task automatic t_bursts;
        asbmp_pkg::asbmp_cmd_s c;
        int                    len [4] = '{1, 4, 8, 1};
        c = '0;
        for (int b = 0; b < 4; b++)
        begin
            c.addr = 32'h0000_2000 + 32'(b) * 32'h40;
            c.wdata = 32'hB0B0_0000 + 32'(b);
            c.burst = 2'(b);
            c.size = `ASBMP_SIZE_WORD;
            c.write = b[0];
            c.lock = b[1];
            run_cmd(c, len[b]);
        end
        $display("test bursts done");
    endtask

    // test slave at word 5 and at the top end of its word window
    task automatic t_test_slave;
        logic [31:0] q;
        test_acc(1'b1, 10'h005, 32'h1234_5678, q);
        test_acc(1'b1, 10'h3FF, 32'h0000_00A5, q);
        test_acc(1'b0, 10'h005, 32'h0000_0000, q);
        check(q, 32'h1234_5678);
        test_acc(1'b0, 10'h3FF, 32'h0000_0000, q);
        check(q, 32'h0000_00A5);
        $display("test slave done");
    endtask

    // mid-run core reset: width, idle bus, then a working transfer
    task automatic t_reset;
        asbmp_pkg::asbmp_cmd_s c;
        int                    n;
        n = 0;
        @(posedge CLK);
        reset_req <= 1'b1;
        @(posedge CLK);
        reset_req <= 1'b0;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge CLK);
            if (core_rst_n === 1'b0)
                n++;
            else if (n > 0)
                break;
            if (n == 1)
                check(32'({bus.bus_request_out, bus.addr_drive_enable}),
                    32'h0);
        end
        check(32'(n >= `ASBMP_RESET_CYCLES), 32'h1);
        c = '0;
        c.addr = 32'h0000_3000;
        c.write = 1'b1;
        c.wdata = 32'h5A5A_A5A5;
        run_cmd(c, 1);
        $display("test reset done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        CLK = 1'b0;
        rst_n = 1'b0;
        reset_req = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        test_valid = 1'b0;
        test_write = 1'b0;
        test_addr = '0;
        test_wdata = 32'h0000_0000;
        n_fail = 0;
        n_compared = 0;
        wr_last = 32'h0000_0000;
        repeat (3) @(posedge CLK);
        rst_n <= 1'b1;
        for (int k = 0; k < 40 && core_rst_n !== 1'b1; k++)
            @(negedge CLK);
        if (core_rst_n !== 1'b1)
            timeout_hit;
        t_sizes;
        t_bursts;
        t_test_slave;
        t_reset;
        report_and_stop;
    end
endmodule
